// ===== swjps_params.svh
// Purpose: Constants for the debug protocol-select watcher.
// Assumes: Select patterns are compared with the oldest sampled bit in bit 15.
// Notes:   Definitions only; included by the watcher.
`ifndef SWJPS_PARAMS_SVH
`define SWJPS_PARAMS_SVH

// Length of every select pattern, in sampled bits.
`define SWJPS_SEQ_LEN 16
// Pattern that moves the port from JTAG to the two-wire protocol.
`define SWJPS_SEQ_TO_WIRE 16'h79e7
// Pattern that moves the port from the two-wire protocol to JTAG.
`define SWJPS_SEQ_TO_JTAG 16'h3ce7
// Pattern that moves the port from the two-wire protocol to Dormant.
`define SWJPS_SEQ_TO_DORM 16'h3dc7
// Locked zero-bit-scan count that sends a JTAG port to Dormant.
`define SWJPS_ZBS_DORM_COUNT 3'h6
// Reset value of the pattern history and of the start-condition history.
`define SWJPS_HIST_RESET 16'h0000
// Reset value of the watcher's armed flag.
`define SWJPS_ARMED_RESET 1'b1

`endif

// ===== swjps_pkg.sv
// Purpose: Types shared by the protocol-select watcher and its users.
// Assumes: TAP state codes match those driven by the TAP controller.
// Notes:   Constants live in swjps_params.svh.
`default_nettype none

package swjps_pkg;

    // Selected protocol of the shared port.
    typedef enum logic [1:0] {
        SWJPS_JTAG = 2'b00,
        SWJPS_WIRE = 2'b01,
        SWJPS_DORM = 2'b10
    } swjps_mode_e;

    // TAP controller states as reported by the TAP.
    typedef enum logic [3:0] {
        TAP_LOGIC_RESET = 4'h0,
        TAP_RUN_IDLE    = 4'h1,
        TAP_SEL_DR      = 4'h2,
        TAP_CAPTURE_DR  = 4'h3,
        TAP_SHIFT_DR    = 4'h4,
        TAP_EXIT1_DR    = 4'h5,
        TAP_PAUSE_DR    = 4'h6,
        TAP_EXIT2_DR    = 4'h7,
        TAP_UPDATE_DR   = 4'h8,
        TAP_SEL_IR      = 4'h9,
        TAP_CAPTURE_IR  = 4'ha,
        TAP_SHIFT_IR    = 4'hb,
        TAP_EXIT1_IR    = 4'hc,
        TAP_PAUSE_IR    = 4'hd,
        TAP_EXIT2_IR    = 4'he,
        TAP_UPDATE_IR   = 4'hf
    } swjps_tap_e;

    // Zero-bit-scan report from the TAP side.
    typedef struct packed {
        logic       locked;
        logic [2:0] count;
    } swjps_zbs_s;

    // Status presented to the protocol engines.
    typedef struct packed {
        swjps_mode_e mode;
        logic        armed;
    } swjps_status_s;

endpackage : swjps_pkg

`default_nettype wire

// ===== swjps_probe.sv
// Purpose: Behavioural debug probe that clocks select patterns onto the shared pins.
// Assumes: Debug clock period 400 ns; the mode/data line has a pull-up.
// Notes:   The debug clock stands low between frames and the data line floats high.
`default_nettype none

module swjps_probe (
    // Frame request from the bench.
    input wire logic i_start,
    input wire logic [15:0] i_pattern,
    input wire logic i_low_clk,
    // Frame status and the two debug pins.
    output logic o_busy,
    output logic o_clk_pin,
    output logic o_data_pin
);
    timeunit 1ns;
    timeprecision 1ns;

    localparam int HALF_NS = 200;
    localparam int HIGHS = 50;

    ////////////////////////////////////////////////////////////////////////////////
    // One bit: data changes while the clock is low, so the device sees it settled.
    task automatic send_bit(input logic b);
        o_data_pin = b;
        #HALF_NS;
        o_clk_pin = 1'h1;
        #HALF_NS;
        o_clk_pin = 1'h0;
    endtask : send_bit

    // Each frame is a high preamble, the pattern oldest bit first, then more highs.
    // A low-clock request sends a single low bit, as used after a JTAG wake-up.
    initial begin
        o_busy = 1'h0;
        o_clk_pin = 1'h0;
        o_data_pin = 1'h1;
        forever begin
            @(posedge i_start or posedge i_low_clk);
            o_busy = 1'h1;
            if (i_low_clk) begin
                send_bit(1'h0);
            end else begin
                repeat (HIGHS) send_bit(1'h1);
                for (int i = 15; i >= 0; i--) send_bit(i_pattern[i]);
                repeat (HIGHS) send_bit(1'h1);
            end
            o_data_pin = 1'h1;
            o_busy = 1'h0;
        end
    end

endmodule : swjps_probe

`default_nettype wire

// ===== swjps_watcher.sv
// Purpose: Watches the shared mode/data pin and selects JTAG, two-wire or Dormant.
// Assumes: Debug clock and mode/data pin are asynchronous; TAP and engine inputs are
//          on i_sys_clk. Debug clock is much slower than i_sys_clk.
// Notes:   Dormant wake-up codes are decoded outside and arrive as one-cycle pulses.
`default_nettype none
`include "swjps_params.svh"

// Notes on behaviour
// - Watch the mode/data pin for 16-bit patterns switching JTAG and two-wire.
// - After reset the port runs JTAG with no pattern needed.
// - Switch by pattern only while the selected interface sits in its reset state.
// - The TAP powers up in Test-Logic-Reset.
// - After a switch, ignore further patterns until the new protocol resets; the Dormant pattern 0x3DC7 is not gated on armed_q.
// - Re-arm on Test-Logic-Reset under JTAG or line reset under two-wire.
// - Under JTAG, accept the to-wire pattern only if it began in Test-Logic-Reset.
// - The to-wire pattern is 0x79E7 most significant bit first.
// - Two-wire starts in reset; probe leaves it by reading the identification register.
// - Under two-wire, accept the to-JTAG pattern only from line reset.
// - The to-JTAG pattern is 0x3CE7 most significant bit first.
// - Each full pattern lands in the requested protocol, harming no engine.
// - Provide a quiescent Dormant state.
// - Dormant can be entered from JTAG and from two-wire.
// - Leaving Dormant for JTAG, the TAP is in Test-Logic-Reset or Run-Test/Idle.
// - The TAP may be reset while JTAG is not selected.
// - Waking to two-wire leaves that interface in its reset state.
// - From line reset, pattern 0x3DC7 sends the port to Dormant.
// - Under JTAG, Run-Test/Idle with locked zero-bit-scan count six enters Dormant.
// - Probe leaves Dormant by alert sequence, four low clocks, then activation code.
module swjps_watcher (
    // Clock, reset and enable.
    input wire logic i_sys_clk,
    input wire logic i_rst,
    input wire logic i_clk_en,
    // Debug pins from the probe.
    input wire logic i_shared_debug_clock_pin,
    input wire logic i_shared_mode_data_pin,
    // Reports from the TAP controller and the two-wire engine.
    input wire swjps_pkg::swjps_tap_e i_tap_state,
    input wire swjps_pkg::swjps_zbs_s i_zero_bit_scan,
    input wire logic i_wire_line_reset,
    // Wake-up pulses from the Dormant exit decoder.
    input wire logic i_wake_to_jtag,
    input wire logic i_wake_to_wire,
    // Selection status and engine controls.
    output swjps_pkg::swjps_status_s o_status,
    output logic o_wire_enter_reset,
    output logic o_select_changed
);

    ////////////////////////////////////////////////////////////////////////////
    // Pin synchronisers and debug clock edge detection.

    logic clk_meta_q, clk_sync_q, clk_prev_q;
    logic dat_meta_q, dat_sync_q;
    logic clk_meta_d, clk_sync_d, clk_prev_d;
    logic dat_meta_d, dat_sync_d;
    logic dbg_rise;

    // Both pins pass two flops on the same path so data stays aligned with its clock.
    always_comb begin
        clk_meta_d = clk_meta_q;
        clk_sync_d = clk_sync_q;
        clk_prev_d = clk_prev_q;
        dat_meta_d = dat_meta_q;
        dat_sync_d = dat_sync_q;
        if (i_clk_en) begin
            clk_meta_d = i_shared_debug_clock_pin;
            clk_sync_d = clk_meta_q;
            clk_prev_d = clk_sync_q;
            dat_meta_d = i_shared_mode_data_pin;
            dat_sync_d = dat_meta_q;
        end
    end

    // Registers the synchroniser stages.
    always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            clk_meta_q <= 1'b0;
            clk_sync_q <= 1'b0;
            clk_prev_q <= 1'b0;
            dat_meta_q <= 1'b0;
            dat_sync_q <= 1'b0;
        end else begin
            clk_meta_q <= clk_meta_d;
            clk_sync_q <= clk_sync_d;
            clk_prev_q <= clk_prev_d;
            dat_meta_q <= dat_meta_d;
            dat_sync_q <= dat_sync_d;
        end
    end

    // A rise of the debug clock is one sample slot of the pin.
    assign dbg_rise = i_clk_en & clk_sync_q & ~clk_prev_q;

    ////////////////////////////////////////////////////////////////////////////
    // Pattern history and start-condition history.

    logic [`SWJPS_SEQ_LEN-1:0] hist_q, hist_d;
    logic [`SWJPS_SEQ_LEN-1:0] start_q, start_d;
    logic in_reset_now;
    swjps_pkg::swjps_mode_e mode_q, mode_d;
    logic armed_q, armed_d;

    // The interface reset state that a pattern must begin in for the current mode.
    assign in_reset_now = (mode_q == swjps_pkg::SWJPS_JTAG) ?
                          (i_tap_state == swjps_pkg::TAP_LOGIC_RESET) :
                          i_wire_line_reset;

    // Shifts one pin sample and its start condition per debug clock rise.
    always_comb begin
        hist_d = hist_q;
        start_d = start_q;
        if (dbg_rise) begin
            hist_d = {hist_q[`SWJPS_SEQ_LEN-2:0], dat_sync_q};
            start_d = {start_q[`SWJPS_SEQ_LEN-2:0], in_reset_now};
        end
    end

    // Registers the histories.
    always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            hist_q <= `SWJPS_HIST_RESET;
            start_q <= `SWJPS_HIST_RESET;
        end else begin
            hist_q <= hist_d;
            start_q <= start_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Protocol selection state machine.

    logic seq_ok;
    logic hit_wire, hit_jtag, hit_dorm, zbs_dorm;
    logic wire_rst_d, wire_rst_q, changed_d, changed_q;

    // A pattern counts only on a fresh sample whose first bit began in reset.
    assign seq_ok = dbg_rise & start_d[`SWJPS_SEQ_LEN-1];
    assign hit_wire = seq_ok & armed_q & (hist_d == `SWJPS_SEQ_TO_WIRE);
    assign hit_jtag = seq_ok & armed_q & (hist_d == `SWJPS_SEQ_TO_JTAG);
    assign hit_dorm = seq_ok & (hist_d == `SWJPS_SEQ_TO_DORM);
    assign zbs_dorm = (i_tap_state == swjps_pkg::TAP_RUN_IDLE) & i_zero_bit_scan.locked &
                      (i_zero_bit_scan.count == `SWJPS_ZBS_DORM_COUNT);

    // Next mode, armed flag and one-cycle engine controls.
    always_comb begin
        mode_d = mode_q;
        armed_d = armed_q;
        wire_rst_d = 1'b0;
        changed_d = 1'b0;
        if (i_clk_en) begin
            case (mode_q)
                swjps_pkg::SWJPS_JTAG: begin
                    if (i_tap_state == swjps_pkg::TAP_LOGIC_RESET) begin
                        armed_d = 1'b1;
                    end
                    if (hit_wire) begin
                        mode_d = swjps_pkg::SWJPS_WIRE;
                        armed_d = 1'b0;
                        wire_rst_d = 1'b1;
                        changed_d = 1'b1;
                    end else if (hit_jtag) begin
                        armed_d = 1'b0;
                    end else if (zbs_dorm) begin
                        mode_d = swjps_pkg::SWJPS_DORM;
                        changed_d = 1'b1;
                    end
                end
                swjps_pkg::SWJPS_WIRE: begin
                    if (i_wire_line_reset) begin
                        armed_d = 1'b1;
                    end
                    if (hit_jtag) begin
                        mode_d = swjps_pkg::SWJPS_JTAG;
                        armed_d = 1'b0;
                        changed_d = 1'b1;
                    end else if (hit_wire) begin
                        armed_d = 1'b0;
                        wire_rst_d = 1'b1;
                    end else if (hit_dorm) begin
                        mode_d = swjps_pkg::SWJPS_DORM;
                        changed_d = 1'b1;
                    end
                end
                swjps_pkg::SWJPS_DORM: begin
                    // Patterns are ignored here; only a wake-up code leaves Dormant.
                    armed_d = 1'b0;
                    if (i_wake_to_jtag) begin
                        mode_d = swjps_pkg::SWJPS_JTAG;
                        changed_d = 1'b1;
                    end else if (i_wake_to_wire) begin
                        mode_d = swjps_pkg::SWJPS_WIRE;
                        wire_rst_d = 1'b1;
                        changed_d = 1'b1;
                    end
                end
                default: begin
                    mode_d = swjps_pkg::SWJPS_JTAG;
                    armed_d = 1'b0;
                end
            endcase
        end
    end

    // Registers the selection state; JTAG is chosen out of reset.
    always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            mode_q <= swjps_pkg::SWJPS_JTAG;
            armed_q <= `SWJPS_ARMED_RESET;
            wire_rst_q <= 1'b0;
            changed_q <= 1'b0;
        end else begin
            mode_q <= mode_d;
            armed_q <= armed_d;
            wire_rst_q <= wire_rst_d;
            changed_q <= changed_d;
        end
    end

    // Outputs come straight from the state flops.
    assign o_status = '{mode: mode_q, armed: armed_q};
    assign o_wire_enter_reset = wire_rst_q;
    assign o_select_changed = changed_q;

    ////////////////////////////////////////////////////////////////////////////
    // Checks.

    logic out_of_rst_q;

    // Marks every cycle after the first one following reset.
    always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            out_of_rst_q <= 1'b0;
        end else begin
            out_of_rst_q <= 1'b1;
        end
    end

    property p_default_jtag;
        @(posedge i_sys_clk) disable iff (i_rst)
        !out_of_rst_q |-> (mode_q == swjps_pkg::SWJPS_JTAG);
    endproperty
    a_default_jtag: assert property (p_default_jtag)
        else $error("Port did not start in JTAG.");

    property p_to_wire;
        @(posedge i_sys_clk) disable iff (i_rst)
        (mode_q == swjps_pkg::SWJPS_JTAG && armed_q && seq_ok &&
         hist_d == `SWJPS_SEQ_TO_WIRE)
        |=> (mode_q == swjps_pkg::SWJPS_WIRE) && wire_rst_q && !armed_q;
    endproperty
    a_to_wire: assert property (p_to_wire)
        else $error("To-wire pattern did not select two-wire.");

    property p_to_jtag;
        @(posedge i_sys_clk) disable iff (i_rst)
        (mode_q == swjps_pkg::SWJPS_WIRE && armed_q && seq_ok &&
         hist_d == `SWJPS_SEQ_TO_JTAG)
        |=> (mode_q == swjps_pkg::SWJPS_JTAG) ##1 !o_select_changed;
    endproperty
    a_to_jtag: assert property (p_to_jtag)
        else $error("To-JTAG pattern did not select JTAG.");

    property p_locked_out;
        @(posedge i_sys_clk) disable iff (i_rst)
        (mode_q == swjps_pkg::SWJPS_WIRE && !armed_q)
        |=> (mode_q != swjps_pkg::SWJPS_JTAG);
    endproperty
    a_locked_out: assert property (p_locked_out)
        else $error("Switch taken while watcher was locked out.");

    property p_rearm_tlr;
        @(posedge i_sys_clk) disable iff (i_rst)
        (i_clk_en && mode_q == swjps_pkg::SWJPS_JTAG && !hit_wire && !hit_jtag &&
         i_tap_state == swjps_pkg::TAP_LOGIC_RESET) |=> armed_q;
    endproperty
    a_rearm_tlr: assert property (p_rearm_tlr)
        else $error("Watcher did not re-arm in Test-Logic-Reset.");

    property p_start_in_tlr;
        @(posedge i_sys_clk) disable iff (i_rst)
        (mode_q == swjps_pkg::SWJPS_JTAG && dbg_rise && !start_d[`SWJPS_SEQ_LEN-1])
        |=> (mode_q != swjps_pkg::SWJPS_WIRE);
    endproperty
    a_start_in_tlr: assert property (p_start_in_tlr)
        else $error("To-wire pattern taken outside Test-Logic-Reset.");

    property p_zbs_dormant;
        @(posedge i_sys_clk) disable iff (i_rst)
        (i_clk_en && mode_q == swjps_pkg::SWJPS_JTAG && !hit_wire && !hit_jtag && zbs_dorm)
        |=> (mode_q == swjps_pkg::SWJPS_DORM) && o_select_changed;
    endproperty
    a_zbs_dormant: assert property (p_zbs_dormant)
        else $error("Locked count of six did not enter Dormant.");

    property p_wire_starts_reset;
        @(posedge i_sys_clk) disable iff (i_rst)
        $rose(mode_q == swjps_pkg::SWJPS_WIRE) |-> wire_rst_q ##1 !wire_rst_q;
    endproperty
    a_wire_starts_reset: assert property (p_wire_starts_reset)
        else $error("Two-wire entered without its reset pulse.");

    property p_sample;
        @(posedge i_sys_clk) disable iff (i_rst)
        dbg_rise |=> (hist_q[0] == $past(dat_sync_q));
    endproperty
    a_sample: assert property (p_sample)
        else $error("Pin sample missing from history.");

endmodule : swjps_watcher

`default_nettype wire

// ===== tb_top.sv
// Purpose: Self-checking bench for the protocol-select watcher.
// Assumes: TAP, line-reset and wake inputs are driven by the bench at falling edges.
// Notes:   Table rows cover pattern cases in order; wake, freeze and reset follow.
`default_nettype none

module tb_top;
    timeunit 1ns;
    timeprecision 1ns;

    typedef struct packed {
        logic [3:0] tap;
        logic lr;
        logic [15:0] pat;
        logic [1:0] mode;
        logic armed;
        logic care;
        logic [1:0] chg;
        logic [1:0] wr;
    } swjps_row_s;

    localparam logic [3:0] TLR = swjps_pkg::TAP_LOGIC_RESET;
    localparam logic [3:0] RTI = swjps_pkg::TAP_RUN_IDLE;
    localparam logic [1:0] JT = swjps_pkg::SWJPS_JTAG;
    localparam logic [1:0] WR = swjps_pkg::SWJPS_WIRE;
    localparam logic [1:0] DM = swjps_pkg::SWJPS_DORM;
    localparam int LIMIT = 40000;

    logic sys_clk, rst, clk_en, dbg_clk, dbg_data, line_rst, wake_jt, wake_wr;
    logic start, low_clk, busy, chg, wr_rst;
    logic [15:0] pat;
    swjps_pkg::swjps_tap_e tap;
    swjps_pkg::swjps_zbs_s zero_bit_scan;
    swjps_pkg::swjps_status_s status;
    int n_mismatch, num_checks, n_chg, n_wr, cycles, c0, w0;
    swjps_row_s rows [12];

    ////////////////////////////////////////////////////////////////////////////////
    swjps_watcher dut (
        .i_sys_clk(sys_clk), .i_rst(rst), .i_clk_en(clk_en),
        .i_shared_debug_clock_pin(dbg_clk), .i_shared_mode_data_pin(dbg_data),
        .i_tap_state(tap), .i_zero_bit_scan(zero_bit_scan), .i_wire_line_reset(line_rst),
        .i_wake_to_jtag(wake_jt), .i_wake_to_wire(wake_wr),
        .o_status(status), .o_wire_enter_reset(wr_rst), .o_select_changed(chg)
    );

    swjps_probe probe (
        .i_start(start), .i_pattern(pat), .i_low_clk(low_clk), .o_busy(busy),
        .o_clk_pin(dbg_clk),
        .o_data_pin(dbg_data)
    );

    // Clock at 20 MHz.
    initial begin
        sys_clk = 1'h0;
        forever #25 sys_clk = ~sys_clk;
    end

    // Counts the one-cycle pulses, and cuts a hang short.
    always @(posedge sys_clk) begin
        cycles <= cycles + 1;
        if (!rst && chg === 1'h1) n_chg++;
        if (!rst && wr_rst === 1'h1) n_wr++;
        if (cycles == LIMIT) begin
            n_mismatch++;
            summarize();
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Compares one value and reports a difference.
    task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string what);
        num_checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED at %0t: %s seen %h expected %h", $time, what, seen, exp);
        end
    endtask : check

    // Sends one framed pattern through the probe and lets the result settle.
    task automatic send(input logic [15:0] p);
        int k;
        pat = p;
        start = 1'h1;
        k = 0;
        while (busy !== 1'h1 && k < 100) begin
            @(negedge sys_clk);
            k++;
        end
        start = 1'h0;
        k = 0;
        while (busy !== 1'h0 && k < 2000) begin
            @(negedge sys_clk);
            k++;
        end
        repeat (8) @(negedge sys_clk);
    endtask : send

    // Gives one wake pulse of either kind.
    task automatic wake(input logic to_jtag);
        wake_jt = to_jtag;
        wake_wr = ~to_jtag;
        @(negedge sys_clk);
        wake_jt = 1'h0;
        wake_wr = 1'h0;
        repeat (4) @(negedge sys_clk);
    endtask : wake

    // Prints the counts and the verdict, then ends the run.
    task automatic summarize;
        $display("Counts: checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : summarize

    ////////////////////////////////////////////////////////////////////////////////
    // Main sequence: reset, table rows, then the hand-written cases.
    initial begin
        rst = 1'h1;
        clk_en = 1'h1;
        tap = swjps_pkg::TAP_LOGIC_RESET;
        zero_bit_scan = '{1'h0, 3'h0};
        line_rst = 1'h0;
        wake_jt = 1'h0;
        wake_wr = 1'h0;
        start = 1'h0;
        low_clk = 1'h0;
        pat = 16'hffff;
        rows = '{
            '{TLR, 1'h0, 16'h79e7, WR, 1'h0, 1'h1, 2'h1, 2'h1},
            '{TLR, 1'h0, 16'h3ce7, WR, 1'h0, 1'h1, 2'h0, 2'h0},
            '{TLR, 1'h1, 16'hffff, WR, 1'h1, 1'h1, 2'h0, 2'h0},
            '{TLR, 1'h1, 16'h79e7, WR, 1'h1, 1'h1, 2'h0, 2'h1},
            '{TLR, 1'h1, 16'hffff, WR, 1'h1, 1'h1, 2'h0, 2'h0},
            '{TLR, 1'h0, 16'h3ce7, WR, 1'h1, 1'h1, 2'h0, 2'h0},
            '{RTI, 1'h1, 16'h3ce7, JT, 1'h0, 1'h1, 2'h1, 2'h0},
            '{TLR, 1'h0, 16'hffff, JT, 1'h1, 1'h1, 2'h0, 2'h0},
            '{RTI, 1'h0, 16'h79e7, JT, 1'h1, 1'h1, 2'h0, 2'h0},
            '{TLR, 1'h0, 16'h79e7, WR, 1'h0, 1'h1, 2'h1, 2'h1},
            '{TLR, 1'h1, 16'h3dc7, DM, 1'h0, 1'h0, 2'h1, 2'h0},
            '{TLR, 1'h1, 16'h79e7, DM, 1'h0, 1'h0, 2'h0, 2'h0}};
        repeat (20) @(negedge sys_clk);
        rst = 1'h0;
        repeat (4) @(negedge sys_clk);
        check(16'(status.mode), 16'(JT), "mode after reset");
        check(16'(status.armed), 16'h1, "armed after reset");
        foreach (rows[i]) begin
            tap = swjps_pkg::swjps_tap_e'(rows[i].tap);
            line_rst = rows[i].lr;
            c0 = n_chg;
            w0 = n_wr;
            send(rows[i].pat);
            check(16'(status.mode), 16'(rows[i].mode), "row mode");
            if (rows[i].care) check(16'(status.armed), 16'(rows[i].armed), "row armed");
            check(16'(n_chg - c0), 16'(rows[i].chg), "row change pulses");
            check(16'(n_wr - w0), 16'(rows[i].wr), "row wire reset pulses");
        end
        tap = swjps_pkg::TAP_RUN_IDLE;
        line_rst = 1'h0;
        c0 = n_chg;
        wake(1'h1);
        check(16'(status.mode), 16'(JT), "wake to jtag");
        check(16'(status.armed), 16'h0, "armed after jtag wake");
        check(16'(n_chg - c0), 16'h1, "wake change pulse");
        low_clk = 1'h1;
        @(negedge sys_clk);
        low_clk = 1'h0;
        repeat (20) @(negedge sys_clk);
        check(16'(status.mode), 16'(JT), "mode after low clock");
        check(16'(n_chg - c0), 16'h1, "no change from low clock");
        zero_bit_scan = '{1'h1, 3'h6};
        repeat (4) @(negedge sys_clk);
        check(16'(status.mode), 16'(DM), "zero-bit-scan dormant");
        zero_bit_scan = '{1'h0, 3'h0};
        w0 = n_wr;
        wake(1'h0);
        check(16'(status.mode), 16'(WR), "wake to wire");
        check(16'(n_wr - w0), 16'h1, "wire reset on wake");
        line_rst = 1'h1;
        repeat (4) @(negedge sys_clk);
        clk_en = 1'h0;
        send(16'h3ce7);
        clk_en = 1'h1;
        check(16'(status.mode), 16'(WR), "frozen watcher");
        wake(1'h1);
        check(16'(status.mode), 16'(WR), "wake outside dormant");
        rst = 1'h1;
        repeat (3) @(negedge sys_clk);
        rst = 1'h0;
        repeat (3) @(negedge sys_clk);
        check(16'(status.mode), 16'(JT), "mode after second reset");
        check(16'(status.armed), 16'h1, "armed after second reset");
        summarize();
    end

endmodule : tb_top

`default_nettype wire
